// >>> verilog/sadc_cfg.svh
// Register map, field positions, reset values and timing counts of the converter sequencer.
// Assumes inclusion by the package and by the sequencer; definitions only.
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH

// =====================================================================
// Bus geometry
`define SADC_AW          18
`define SADC_DW          32
`define SADC_WORD_LSB    2
`define SADC_IDX_W       16

// =====================================================================
// Register indices, byte address is four times the index
`define SADC_IDX_RESULT  16'hff18
`define SADC_IDX_RES_HI  16'hff1a
`define SADC_IDX_DIR     16'hff22
`define SADC_IDX_MODE    16'hff80
`define SADC_IDX_CHAN    16'hff81
`define SADC_IDX_ASEL    16'hff84

// =====================================================================
// Reset values, writable masks and forced-one direction bits
`define SADC_MODE_RST    8'h00
`define SADC_CHAN_RST    8'h00
`define SADC_DIR_RST     8'hff
`define SADC_ASEL_RST    8'h00
`define SADC_MODE_MASK   8'hb9
`define SADC_CHAN_MASK   8'h03
`define SADC_DIR_FIXED   8'hf0
`define SADC_ASEL_MASK   8'h0f

// =====================================================================
// Field positions
`define SADC_MODE_START  7
`define SADC_MODE_CEN    0
`define SADC_TS_HI       5
`define SADC_TS_LO       3
`define SADC_CH_HI       1
`define SADC_PINS        4
`define SADC_RES_BITS    10
`define SADC_HI_LSB      2
`define SADC_BIT_W       4
`define SADC_MSB_BIT     4'h9
`define SADC_MSB_TRIAL   10'h200

// =====================================================================
// Sampling and total conversion periods in peripheral clocks
`define SADC_CNT_W       8
`define SADC_SMP_000     8'd12
`define SADC_CNV_000     8'd36
`define SADC_SMP_100     8'd24
`define SADC_CNV_100     8'd72
`define SADC_SMP_110     8'd96
`define SADC_CNV_110     8'd144
`define SADC_SMP_101     8'd48
`define SADC_CNV_101     8'd96
`define SADC_SMP_010     8'd48
`define SADC_CNV_010     8'd72
`define SADC_SMP_001     8'd24
`define SADC_CNV_001     8'd48
`define SADC_SMP_111     8'd176
`define SADC_CNV_111     8'd224
`define SADC_SMP_011     8'd88
`define SADC_CNV_011     8'd112

`endif

// >>> verilog/sadc_pkg.sv
// Types shared by the converter sequencer files.
// Assumes sadc_cfg.svh on the include path.
`include "sadc_cfg.svh"

package sadc_pkg;

   // ==================================================================
   // Sequencer states
   typedef enum logic [2:0] {
      SADC_IDLE    = 3'b001,
      SADC_SAMPLE  = 3'b010,
      SADC_CONVERT = 3'b100
   } sadc_state_t;

   // ==================================================================
   // Phase lengths for one time_select code
   typedef struct packed {
      logic [`SADC_CNT_W-1:0] samp;
      logic [`SADC_CNT_W-1:0] slice;
   } sadc_timing_t;

   // ==================================================================
   // Controls toward the sample-and-hold, comparator and tap selector
   typedef struct packed {
      logic                      sample;
      logic                      comp_en;
      logic [`SADC_CH_HI:0]      channel;
      logic [`SADC_RES_BITS-1:0] tap;
   } sadc_analog_t;

endpackage

// >>> verilog/sadc_rst_sync.sv
// Reset release synchroniser for the converter sequencer.
// Assumes an asynchronous active-low reset and one free-running clock.
`timescale 1ns/100ps
`default_nettype none

module sadc_rst_sync (
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   output logic      rst_n_o
);

   logic stage_r;

   // Assert at once, release two edges later
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stage_r <= 1'b0;
         rst_n_o <= 1'b0;
      end else begin
         stage_r <= 1'b1;
         rst_n_o <= stage_r;
      end
   end

endmodule

`default_nettype wire

// >>> verilog/sadc_seq.sv
// Successive-approximation converter sequencer with APB register file.
// Assumes an on-chip comparator whose comp_i answers the current tap on this clock.
//
// Behaviour
// [R1] Result word is 16 bits, upper six read zero, low ten hold the result.
// [R2] Conversion end copies the approximation into the result word, bits 9:8 upper byte.
// [R3] Software reads the result word with a full access only.
// [R4] Result word and high byte are not reset and undefined until first result.
// [R5] Software reads the result before writing mode or channel registers.
// [R6] Result high byte presents result bits 9 to 2.
// [R7] Direction bit 0 drives the pin, 1 makes it input; bits 7:4 read one.
// [R8] Analog-mode bit 1 routes pin to converter and blocks port use.
// [R9] Software sets direction and analog-mode bits for analog inputs.
// [R10] Software clears pull-ups of pins in analog mode.
// [R11] Software selects channel, enables comparator, waits, then sets start.
// [R12] After start the input is sampled for the set time, then held.
// [R13] First trial sets bit 9 against the half-supply tap.
// [R14] Each lower bit is tried at one, kept when input is at least the tap.
// [R15] After ten decisions the result loads and the done interrupt pulses.
// [R16] Conversions repeat back to back while start stays one.
// [R17] Clearing start stops conversion.
// [R18] Software restarts with the gap, adding stabilisation if comparator was off.
// [R19] Mode or channel write aborts a conversion; restart from sampling if start.
// [R20] Ideal code is integer of input ratio times 1024 plus one half.
// [R21] Only single-channel select mode exists.
// [R22] Channel code 0 to 3 selects inputs 0 to 3; upper bits zero.
// [R23] Mode bit 7 start, bit 0 comparator enable, bits 5:3 time select.
// [R24] A read beats a result load; a mode or channel write cancels it.
// [R25] Start works with comparator off; first result then is unreliable.
// [R26] Timing counts clocks, one bit decision per fixed slice.
// [R27] High byte is a view of result word bits 9:2, updated together.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

`include "sadc_cfg.svh"

module sadc_seq
   import sadc_pkg::*;
(
   input  wire logic                     clock_i,
   input  wire logic                     rst_n_i,
   input  wire logic                     psel_i,
   input  wire logic                     penable_i,
   input  wire logic                     pwrite_i,
   input  wire logic [`SADC_AW-1:0]      paddr_i,
   input  wire logic [`SADC_DW-1:0]      pwdata_i,
   output logic      [`SADC_DW-1:0]      prdata_o,
   output logic                          pready_o,
   output logic                          pslverr_o,
   input  wire logic                     comp_i,
   output sadc_analog_t                  analog_o,
   output logic                          conversion_done_irq_o,
   output logic      [`SADC_PINS-1:0]    pin_output_en_o,
   output logic      [`SADC_PINS-1:0]    pin_analog_sel_o
);

   // ==================================================================
   // Helpers
   function automatic logic sadc_hit(input logic [`SADC_AW-1:0]  a,
                                     input logic [`SADC_IDX_W-1:0] idx);
      return (a[`SADC_AW-1:`SADC_WORD_LSB] == idx) && (a[`SADC_WORD_LSB-1:0] == '0);
   endfunction

   function automatic sadc_timing_t sadc_timing(input logic [2:0] ts);
      logic [`SADC_CNT_W-1:0] s;
      logic [`SADC_CNT_W-1:0] c;
      sadc_timing_t           t;
      s = `SADC_SMP_000;
      c = `SADC_CNV_000;
      case (ts)
         3'h4: begin s = `SADC_SMP_100; c = `SADC_CNV_100; end
         3'h6: begin s = `SADC_SMP_110; c = `SADC_CNV_110; end
         3'h5: begin s = `SADC_SMP_101; c = `SADC_CNV_101; end
         3'h2: begin s = `SADC_SMP_010; c = `SADC_CNV_010; end
         3'h1: begin s = `SADC_SMP_001; c = `SADC_CNV_001; end
         3'h7: begin s = `SADC_SMP_111; c = `SADC_CNV_111; end
         3'h3: begin s = `SADC_SMP_011; c = `SADC_CNV_011; end
         default: begin s = `SADC_SMP_000; c = `SADC_CNV_000; end
      endcase
      t.samp  = s;
      // Remainder of the period after ten slices is dropped
      t.slice = `SADC_CNT_W'((c - s) / `SADC_RES_BITS);
      return t;
   endfunction

   // ==================================================================
   // Reset release
   logic rst_n;

   sadc_rst_sync u_rst_sync (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .rst_n_o (rst_n)
   );

   // ==================================================================
   // Declarations
   logic [7:0]                mode_r;
   logic [7:0]                chan_r;
   logic [7:0]                dir_r;
   logic [7:0]                asel_r;
   logic [`SADC_RES_BITS-1:0] result_r;
   logic [`SADC_RES_BITS-1:0] sar_r;
   logic [`SADC_BIT_W-1:0]    bit_r;
   logic [`SADC_CNT_W-1:0]    cnt_r;
   sadc_state_t               state_r;
   logic                      pready_r;
   logic                      pslverr_r;
   logic [`SADC_DW-1:0]       prdata_r;
   logic                      irq_r;
   logic [`SADC_PINS-1:0]     pin_oe_r;
   logic [`SADC_PINS-1:0]     pin_an_r;
   logic [`SADC_DW-1:0]       rdata_nxt;
   logic                      known_nxt;
   logic                      ro_nxt;
   logic                      access;
   logic                      wr_en;
   logic                      mode_wr;
   logic                      chan_wr;
   logic                      start_nxt;
   logic                      slice_end;
   logic                      done;
   sadc_timing_t              tmg;

   // ==================================================================
   // APB slave: one wait state, answer registered
   assign access = psel_i & penable_i;
   assign wr_en  = access & pready_r & pwrite_i & !pslverr_r;
   assign mode_wr = wr_en & sadc_hit(paddr_i, `SADC_IDX_MODE);
   assign chan_wr = wr_en & sadc_hit(paddr_i, `SADC_IDX_CHAN);

   always_comb begin
      rdata_nxt = '0;
      known_nxt = 1'b1;
      ro_nxt    = 1'b0;
      if (sadc_hit(paddr_i, `SADC_IDX_RESULT)) begin
         rdata_nxt[`SADC_RES_BITS-1:0] = result_r;                        // [R1] [R2]
         ro_nxt = 1'b1;
      end else if (sadc_hit(paddr_i, `SADC_IDX_RES_HI)) begin
         rdata_nxt[7:0] = result_r[`SADC_RES_BITS-1:`SADC_HI_LSB];        // [R6] [R27]
         ro_nxt = 1'b1;
      end else if (sadc_hit(paddr_i, `SADC_IDX_MODE)) begin
         rdata_nxt[7:0] = mode_r;
      end else if (sadc_hit(paddr_i, `SADC_IDX_CHAN)) begin
         rdata_nxt[7:0] = chan_r;
      end else if (sadc_hit(paddr_i, `SADC_IDX_DIR)) begin
         rdata_nxt[7:0] = dir_r;
      end else if (sadc_hit(paddr_i, `SADC_IDX_ASEL)) begin
         rdata_nxt[7:0] = asel_r;
      end else begin
         known_nxt = 1'b0;
      end
   end

   // Read data is captured on the same edge as any result load it meets, so it returns the previous result
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= '0;
      end else begin
         pready_r <= access & !pready_r;
         if (access & !pready_r) begin
            prdata_r  <= pwrite_i ? '0 : rdata_nxt;                        // [R24]
            pslverr_r <= !known_nxt | (pwrite_i & ro_nxt);
         end else begin
            pslverr_r <= 1'b0;
         end
      end
   end

   // ==================================================================
   // Control registers
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= `SADC_MODE_RST;
         chan_r <= `SADC_CHAN_RST;
         dir_r  <= `SADC_DIR_RST;
         asel_r <= `SADC_ASEL_RST;
      end else begin
         if (mode_wr)
            mode_r <= pwdata_i[7:0] & `SADC_MODE_MASK;                     // [R23]
         if (chan_wr)
            chan_r <= pwdata_i[7:0] & `SADC_CHAN_MASK;                     // [R22]
         if (wr_en & sadc_hit(paddr_i, `SADC_IDX_DIR))
            dir_r <= pwdata_i[7:0] | `SADC_DIR_FIXED;                      // [R7]
         if (wr_en & sadc_hit(paddr_i, `SADC_IDX_ASEL))
            asel_r <= pwdata_i[7:0] & `SADC_ASEL_MASK;                     // [R8]
      end
   end

   // ==================================================================
   // Sequencer
   assign tmg       = sadc_timing(mode_r[`SADC_TS_HI:`SADC_TS_LO]);         // [R26]
   assign start_nxt = mode_wr ? pwdata_i[`SADC_MODE_START] : mode_r[`SADC_MODE_START];
   assign slice_end = (state_r == SADC_CONVERT) && (cnt_r == tmg.slice - 1'b1);
   // A coinciding mode or channel write cancels the load and the pulse
   assign done      = slice_end && (bit_r == '0) && !(mode_wr | chan_wr);   // [R24]

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= SADC_IDLE;
         cnt_r   <= '0;
         bit_r   <= `SADC_MSB_BIT;
         sar_r   <= '0;
      end else if (mode_wr | chan_wr) begin
         // Start ignores comparator enable; restart always from sampling
         state_r <= start_nxt ? SADC_SAMPLE : SADC_IDLE;                    // [R19] [R17] [R25]
         cnt_r   <= '0;
         bit_r   <= `SADC_MSB_BIT;
      end else begin
         case (state_r)
            SADC_IDLE: begin
               cnt_r <= '0;
            end
            SADC_SAMPLE: begin
               if (cnt_r == tmg.samp - 1'b1) begin                          // [R12]
                  state_r <= SADC_CONVERT;
                  cnt_r   <= '0;
                  bit_r   <= `SADC_MSB_BIT;
                  sar_r   <= `SADC_MSB_TRIAL;                               // [R13]
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            SADC_CONVERT: begin
               if (slice_end) begin
                  cnt_r        <= '0;
                  sar_r[bit_r] <= comp_i;                                   // [R13] [R14] [R20]
                  if (bit_r == '0) begin
                     state_r <= SADC_SAMPLE;                                // [R16]
                  end else begin
                     bit_r                <= bit_r - 1'b1;
                     sar_r[bit_r - 1'b1]  <= 1'b1;                          // [R14]
                  end
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            default: begin
               state_r <= SADC_IDLE;
            end
         endcase
      end
   end

   // Result has no reset value until the first conversion ends
   always_ff @(posedge clock_i) begin
      if (done)
         result_r <= {sar_r[`SADC_RES_BITS-1:1], comp_i};                   // [R2] [R4] [R15]
   end

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n)
         irq_r <= 1'b0;
      else
         irq_r <= done;                                                     // [R15]
   end

   // ==================================================================
   // Shared pins: analog mode wins over the output buffer
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         pin_oe_r <= '0;
         pin_an_r <= '0;
      end else begin
         pin_oe_r <= ~dir_r[`SADC_PINS-1:0] & ~asel_r[`SADC_PINS-1:0];     // [R7] [R8]
         pin_an_r <= asel_r[`SADC_PINS-1:0];                                // [R8]
      end
   end

   // ==================================================================
   // Outputs
   assign prdata_o              = prdata_r;
   assign pready_o              = pready_r;
   assign pslverr_o             = pslverr_r;
   assign conversion_done_irq_o = irq_r;
   assign pin_output_en_o       = pin_oe_r;
   assign pin_analog_sel_o      = pin_an_r;
   assign analog_o.sample       = (state_r == SADC_SAMPLE);
   assign analog_o.comp_en      = mode_r[`SADC_MODE_CEN];
   assign analog_o.channel      = chan_r[`SADC_CH_HI:0];                    // [R21] [R22]
   assign analog_o.tap          = sar_r;

   // ==================================================================
   // Checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n);

   irq_single_a: assert property (irq_r |=> !irq_r)                         // [R15]
      else $error("done pulse longer than one cycle");
   result_load_a: assert property (done |=> irq_r && result_r == $past({sar_r[9:1], comp_i})) // [R2]
      else $error("result not loaded with the done pulse");
   abort_restart_a: assert property ((mode_wr | chan_wr) && state_r != SADC_IDLE
         |=> !irq_r && cnt_r == '0 && state_r != SADC_CONVERT)               // [R19]
      else $error("write did not abort the conversion");
   stop_clear_a: assert property (mode_wr && !pwdata_i[7] |=> state_r == SADC_IDLE ##1
         state_r == SADC_IDLE)                                               // [R17]
      else $error("clearing start did not stop");
   sample_length_a: assert property (state_r == SADC_CONVERT && $past(state_r) == SADC_SAMPLE
         |-> $past(cnt_r) == tmg.samp - 1'b1)                                // [R12]
      else $error("sampling phase length wrong");
   msb_trial_a: assert property (state_r == SADC_CONVERT && $past(state_r) == SADC_SAMPLE
         |-> sar_r == 10'h200 && bit_r == 4'h9)                              // [R13]
      else $error("approximation did not start at bit 9");
   repeat_conv_a: assert property (irq_r && !$past(mode_wr | chan_wr) |-> state_r == SADC_SAMPLE) // [R16]
      else $error("conversion did not repeat");
   high_view_a: assert property (access && !pready_r && !pwrite_i && sadc_hit(paddr_i, `SADC_IDX_RES_HI)
         |=> prdata_r == {24'h0, $past(result_r[9:2])})                      // [R6]
      else $error("high byte read wrong");
   word_upper_a: assert property (access && !pready_r && sadc_hit(paddr_i, `SADC_IDX_RESULT)
         |=> prdata_r[31:10] == '0)                                          // [R1]
      else $error("result upper bits not zero");
   pin_mode_a: assert property (##1 pin_oe_r == $past(~dir_r[3:0] & ~asel_r[3:0])) // [R7]
      else $error("pin output enable wrong");

   conv_done_c: cover property (done ##1 state_r == SADC_SAMPLE);
   abort_c: cover property ((mode_wr | chan_wr) && state_r == SADC_CONVERT);
   read_clash_c: cover property (done && access && !pready_r && !pwrite_i);
   write_clash_c: cover property (slice_end && bit_r == '0 && (mode_wr | chan_wr));

endmodule

`default_nettype wire

// >>> testbench/sadc_comp_model.sv
// Far-side model: sample-and-hold on four inputs plus an ideal comparator.
// Assumes input levels given as ideal 10-bit codes, one per channel.
`timescale 1ns/100ps
`default_nettype none

module sadc_comp_model
   import sadc_pkg::*;
(
   input  wire logic         clock_i,
   input  wire sadc_analog_t analog_i,
   input  wire logic [39:0]  levels_i,
   output logic              comp_o
);
   // ====
   // Hold stage
   logic [9:0] held_r;

   // Inputs are unloaded levels: analog pins carry no pull-up
   // Tracks only while sampling, so a late input change is not seen
   always_ff @(posedge clock_i) begin
      if (analog_i.sample) begin
         held_r <= levels_i[analog_i.channel*10 +: 10];
      end
   end

   // ====
   // Comparator, input at or above the tap answers one
   assign comp_o = (held_r >= analog_i.tap);
endmodule
`default_nettype wire

// >>> testbench/sadc_seq_test.sv
// Self-checking bench for the converter sequencer over APB.
// Assumes the comparator model as far side and the design register map.
`timescale 1ns/100ps
`default_nettype none
`include "sadc_cfg.svh"

module sadc_seq_test;
   import sadc_pkg::*;
   // ====
   // Signals
   logic         clock_i = 1'b0;
   logic         rst_n_i = 1'b0;
   logic         psel    = 1'b0;
   logic         penable = 1'b0;
   logic         pwrite  = 1'b0;
   logic [17:0]  paddr   = 18'h0;
   logic [31:0]  pwdata  = 32'h0;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   logic         comp;
   sadc_analog_t analog;
   logic         irq;
   logic [3:0]   pin_oe;
   logic [3:0]   pin_asel;
   logic [39:0]  levels  = {10'h200, 10'h155, 10'h000, 10'h3ff};
   int           err_total = 0;
   int           n_checks  = 0;
   int           smp [8] = '{12, 24, 48, 88, 24, 48, 96, 176};
   int           cnv [8] = '{36, 48, 72, 112, 72, 96, 144, 224};

   always #5 clock_i = ~clock_i;

   sadc_seq dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .comp_i(comp),
      .analog_o(analog), .conversion_done_irq_o(irq), .pin_output_en_o(pin_oe),
      .pin_analog_sel_o(pin_asel));

   sadc_comp_model model_u (.clock_i(clock_i), .analog_i(analog), .levels_i(levels),
      .comp_o(comp));

   // ====
   // Tasks
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // One idle cycle between transfers keeps psel from toggling in one step
   task automatic apb(input logic wr_en, input logic [15:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge clock_i);
      psel <= 1'b1;
      pwrite <= wr_en;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge clock_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) begin
         chk(32'h1, 32'h0, "pready timeout");
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [15:0] idx, input logic [31:0] wd, input logic eerr);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, idx, wd, rd, err);
      chk({31'h0, err}, {31'h0, eerr}, "write error flag");
   endtask

   task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp, input logic eerr);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, idx, 32'h0, rd, err);
      chk(rd, exp, "read data");
      chk({31'h0, err}, {31'h0, eerr}, "read error flag");
   endtask

   task automatic wait_irq(output int n);
      n = 0;
      do begin
         @(negedge clock_i);
         n++;
      end while (irq !== 1'b1 && n < 3000);
      if (n >= 3000) begin
         chk(32'h1, 32'h0, "irq timeout");
         end_sim();
      end
   endtask

   // ====
   // Sequence
   initial begin
      int n;
      int s;
      int l;
      logic [9:0] e;
      repeat (16) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      rd_chk(`SADC_IDX_DIR, 32'hff, 1'b0);
      rd_chk(`SADC_IDX_ASEL, 32'h00, 1'b0);
      rd_chk(`SADC_IDX_MODE, 32'h00, 1'b0);
      rd_chk(16'h0100, 32'h0, 1'b1);
      wr(`SADC_IDX_RESULT, 32'h1, 1'b1);
      wr(`SADC_IDX_DIR, 32'h0a, 1'b0);
      wr(`SADC_IDX_ASEL, 32'h03, 1'b0);
      rd_chk(`SADC_IDX_DIR, 32'hfa, 1'b0);
      rd_chk(`SADC_IDX_ASEL, 32'h03, 1'b0);
      repeat (2) @(negedge clock_i);
      chk({28'h0, pin_oe}, 32'h4, "pin drive");
      chk({28'h0, pin_asel}, 32'h3, "pin analog");
      $display("test registers done");
      // Analog inputs on all pins, comparator settles before the first start
      wr(`SADC_IDX_DIR, 32'h0f, 1'b0);
      wr(`SADC_IDX_ASEL, 32'h0f, 1'b0);
      wr(`SADC_IDX_MODE, 32'h01, 1'b0);
      repeat (100) @(negedge clock_i);
      chk({28'h0, pin_oe}, 32'h0, "analog pins not driven");
      chk({28'h0, pin_asel}, 32'hf, "analog pins routed");
      // Every time code, channels in turn, latency then repeat period
      for (int i = 0; i < 8; i++) begin
         s = smp[i];
         l = (cnv[i] - s) / 10;
         e = levels[(i % 4)*10 +: 10];
         wr(`SADC_IDX_MODE, 32'h01, 1'b0);
         wr(`SADC_IDX_CHAN, i % 4, 1'b0);
         wr(`SADC_IDX_MODE, 32'h81 | (i << 3), 1'b0);
         wait_irq(n);
         chk(n, s + 10*l + 1, "first result time");
         wait_irq(n);
         chk(n, s + 10*l, "repeat period");
         rd_chk(`SADC_IDX_RESULT, {22'h0, e}, 1'b0);
         rd_chk(`SADC_IDX_RES_HI, {24'h0, e[9:2]}, 1'b0);
         rd_chk(`SADC_IDX_MODE, 32'h81 | (i << 3), 1'b0);
      end
      $display("test conversions done");
      // Channel write mid-conversion restarts from sampling
      wr(`SADC_IDX_MODE, 32'h01, 1'b0);
      wr(`SADC_IDX_CHAN, 32'h0, 1'b0);
      wr(`SADC_IDX_MODE, 32'h81, 1'b0);
      repeat (13) @(negedge clock_i);
      chk({22'h0, analog.tap}, 32'h200, "first trial tap");
      chk({31'h0, analog.sample}, 32'h0, "hold after sampling");
      chk({31'h0, analog.comp_en}, 32'h1, "comparator enable");
      chk({30'h0, analog.channel}, 32'h0, "channel select");
      repeat (7) @(negedge clock_i);
      wr(`SADC_IDX_CHAN, 32'h1, 1'b0);
      wait_irq(n);
      chk(n, 33, "restart time");
      rd_chk(`SADC_IDX_RESULT, 32'h0, 1'b0);
      // Start with the comparator off still converts
      wr(`SADC_IDX_MODE, 32'h80, 1'b0);
      wait_irq(n);
      chk(n, 33, "start with comparator off");
      chk({31'h0, analog.comp_en}, 32'h0, "comparator stays off");
      $display("test abort done");
      // Start cleared: no further results
      wr(`SADC_IDX_MODE, 32'h01, 1'b0);
      n = 0;
      repeat (300) begin
         @(negedge clock_i);
         n += (irq === 1'b1);
      end
      chk(n, 0, "irq after stop");
      chk({31'h0, analog.sample}, 32'h0, "sampling after stop");
      $display("test stop done");
      end_sim();
   end
endmodule
`default_nettype wire
